//--- rtl/dpbr_pkg.sv
// Shared constants and types for the dual-port block memory
package dpbr_pkg;

    // ====================================================================
    // Storage geometry
    // ====================================================================
    localparam int DATA_BITS     = 32;   // Data bits per storage word
    localparam int PAR_BITS      = 4;    // Parity bits per storage word
    localparam int WORD_BITS     = 36;   // Data plus parity
    localparam int STORE_WORDS   = 512;  // 512 x 36 = 18 Kbit
    localparam int WORD_IDX_BITS = 9;    // Index into the storage words
    localparam int ADDR_BITS     = 14;   // Widest port address (16K x 1)
    localparam int LANE_BITS     = 5;    // Bit offset within a data word
    localparam int PLANE_BITS    = 2;    // Bit offset within parity bits
    localparam int BYTE_BITS     = 8;    // Data bits guarded by one parity
    localparam int PAR_WIDTH_MIN = 9;    // Narrowest width carrying parity

    // ====================================================================
    // Default configuration
    // ====================================================================
    localparam int                   DEF_WIDTH    = 36;
    localparam logic                 DEF_INV      = 1'b0;
    localparam logic [WORD_BITS-1:0] DEF_SET_VAL  = 36'h0_0000_0000;
    localparam logic [WORD_BITS-1:0] DEF_INIT_VAL = 36'h0_0000_0000;
    // Port clock seen high at reset so no false edge on release
    localparam logic                 RST_CLK_PREV = 1'b1;

    // ====================================================================
    // Types
    // ====================================================================
    typedef enum {
        DPBR_WRITE_FIRST,
        DPBR_READ_FIRST,
        DPBR_NO_CHANGE
    } dpbr_wmode_t;

    typedef struct packed {
        logic                 clk_prev;  // Last sampled port clock level
        logic [WORD_BITS-1:0] out;       // {parity, data} output register
    } dpbr_port_st_t;

    typedef struct packed {
        dpbr_port_st_t a;
        dpbr_port_st_t b;
    } dpbr_st_t;

endpackage : dpbr_pkg

//--- rtl/dpbr_lane.sv
// Width-dependent address split and lane alignment for one port
`timescale 1ns/1ps
module dpbr_lane
    import dpbr_pkg::*;
#(
    parameter int WIDTH = DEF_WIDTH
)(
    input  wire logic [ADDR_BITS-1:0]     addr_i,   // Port address
    input  wire logic [DATA_BITS-1:0]     wdata_i,  // Write data, low bits
    input  wire logic [PAR_BITS-1:0]      wpar_i,   // Write parity, low bits
    input  wire logic [WORD_BITS-1:0]     rword_i,  // Addressed stored word
    output logic      [WORD_IDX_BITS-1:0] word_o,   // Storage word index
    output logic      [WORD_BITS-1:0]     mask_o,   // Bits this port owns
    output logic      [WORD_BITS-1:0]     wword_o,  // Aligned write word
    output logic      [WORD_BITS-1:0]     rtrim_o,  // Extracted read value
    output logic      [WORD_BITS-1:0]     wtrim_o   // Trimmed write value
);

    // ====================================================================
    // Organisation
    // ====================================================================
    // 9/18/36 split into one parity bit per byte; narrower have none
    localparam int DW = (WIDTH >= PAR_WIDTH_MIN) ?
                        (WIDTH * BYTE_BITS) / PAR_WIDTH_MIN : WIDTH;
    localparam int PW = WIDTH - DW;
    localparam int LW = $clog2(DATA_BITS / DW);
    localparam logic [DATA_BITS-1:0] DMASK =
        DATA_BITS'((64'h1 << DW) - 64'h1);
    localparam logic [PAR_BITS-1:0]  PMASK =
        PAR_BITS'((64'h1 << PW) - 64'h1);
    localparam logic [LANE_BITS-1:0] LMASK =
        LANE_BITS'((64'h1 << LW) - 64'h1);

    logic [LANE_BITS-1:0]  lane;
    logic [LANE_BITS-1:0]  doff;
    logic [PLANE_BITS-1:0] poff;
    logic [DATA_BITS-1:0]  rdata;
    logic [PAR_BITS-1:0]   rpar;

    // ====================================================================
    // Alignment
    // ====================================================================
    // Narrow widths touch only data bits, so they see the 16 Kbit part
    always_comb
    begin
        lane    = LANE_BITS'(addr_i) & LMASK;
        word_o  = WORD_IDX_BITS'(addr_i >> LW);
        doff    = LANE_BITS'(lane * DW);
        poff    = PLANE_BITS'(lane * PW);
        // Parity handled as plain bits: no generation, no check
        mask_o  = {PMASK << poff, DMASK << doff};
        wword_o = {(wpar_i & PMASK) << poff,
                   (wdata_i & DMASK) << doff};
        rdata   = (rword_i[DATA_BITS-1:0] >> doff) & DMASK;
        rpar    = (rword_i[WORD_BITS-1:DATA_BITS] >> poff) & PMASK;
        // Read and write buses are the same width for this port
        rtrim_o = {rpar, rdata};
        wtrim_o = {wpar_i & PMASK, wdata_i & DMASK};
    end

endmodule : dpbr_lane

//--- rtl/dpbr_ram.sv
// Dual-port 18 Kbit block memory with configurable ports
`timescale 1ns/1ps
module dpbr_ram
    import dpbr_pkg::*;
#(
    parameter int                   A_WIDTH    = DEF_WIDTH,
    parameter dpbr_wmode_t          A_MODE     = DPBR_WRITE_FIRST,
    parameter logic                 A_CLK_INV  = DEF_INV,
    parameter logic                 A_EN_INV   = DEF_INV,
    parameter logic                 A_WE_INV   = DEF_INV,
    parameter logic                 A_SET_INV  = DEF_INV,
    parameter logic [WORD_BITS-1:0] A_SET_VAL  = DEF_SET_VAL,
    parameter logic [WORD_BITS-1:0] A_INIT_VAL = DEF_INIT_VAL,
    parameter int                   B_WIDTH    = DEF_WIDTH,
    parameter dpbr_wmode_t          B_MODE     = DPBR_WRITE_FIRST,
    parameter logic                 B_CLK_INV  = DEF_INV,
    parameter logic                 B_EN_INV   = DEF_INV,
    parameter logic                 B_WE_INV   = DEF_INV,
    parameter logic                 B_SET_INV  = DEF_INV,
    parameter logic [WORD_BITS-1:0] B_SET_VAL  = DEF_SET_VAL,
    parameter logic [WORD_BITS-1:0] B_INIT_VAL = DEF_INIT_VAL
)(
    input  wire logic                 sys_clk_i,             // System clock
    input  wire logic                 rst_n_i,               // Sync reset
    input  wire logic                 a_clk_i,               // Port A clock
    input  wire logic                 a_en_i,                // Port A enable
    input  wire logic                 a_we_i,                // Port A write
    input  wire logic                 a_sync_output_set_i,   // Port A set
    input  wire logic [ADDR_BITS-1:0] a_addr_i,              // Port A addr
    input  wire logic [DATA_BITS-1:0] a_write_data_in_i,     // Port A data
    input  wire logic [PAR_BITS-1:0]  a_write_par_i,         // Port A parity
    output logic      [DATA_BITS-1:0] a_read_data_o,         // Port A data
    output logic      [PAR_BITS-1:0]  a_read_par_o,          // Port A parity
    input  wire logic                 b_clk_i,               // Port B clock
    input  wire logic                 b_en_i,                // Port B enable
    input  wire logic                 b_we_i,                // Port B write
    input  wire logic                 b_sync_output_set_i,   // Port B set
    input  wire logic [ADDR_BITS-1:0] b_addr_i,              // Port B addr
    input  wire logic [DATA_BITS-1:0] b_write_data_in_i,     // Port B data
    input  wire logic [PAR_BITS-1:0]  b_write_par_i,         // Port B parity
    output logic      [DATA_BITS-1:0] b_read_data_o,         // Port B data
    output logic      [PAR_BITS-1:0]  b_read_par_o           // Port B parity
);

    // ====================================================================
    // Storage
    // ====================================================================
    logic [WORD_BITS-1:0] mem [STORE_WORDS];

    dpbr_st_t st_ff;
    dpbr_st_t nxt_st;

    logic [WORD_IDX_BITS-1:0] a_word;
    logic [WORD_IDX_BITS-1:0] b_word;
    logic [WORD_BITS-1:0]     a_mask;
    logic [WORD_BITS-1:0]     b_mask;
    logic [WORD_BITS-1:0]     a_wword;
    logic [WORD_BITS-1:0]     b_wword;
    logic [WORD_BITS-1:0]     a_rtrim;
    logic [WORD_BITS-1:0]     b_rtrim;
    logic [WORD_BITS-1:0]     a_wtrim;
    logic [WORD_BITS-1:0]     b_wtrim;
    logic [WORD_BITS-1:0]     a_old;
    logic [WORD_BITS-1:0]     b_old;
    logic [WORD_BITS-1:0]     a_new;
    logic [WORD_BITS-1:0]     b_new;
    logic                     a_clk_eff;
    logic                     b_clk_eff;
    logic                     a_fire;
    logic                     b_fire;
    logic                     a_wr;
    logic                     b_wr;

    // ====================================================================
    // Helpers
    // ====================================================================
    // One enabled active edge of a port; set, write and read share it
    function automatic dpbr_port_st_t port_step(
        input dpbr_port_st_t        cur,
        input logic                 clk_eff,
        input logic                 fire,
        input logic                 we,
        input logic                 set,
        input logic [WORD_BITS-1:0] set_val,
        input dpbr_wmode_t          mode,
        input logic [WORD_BITS-1:0] rd_old,
        input logic [WORD_BITS-1:0] wr_trim
    );
        dpbr_port_st_t nxt;
        nxt          = cur;
        nxt.clk_prev = clk_eff;
        if (fire)
        begin
            if (set)
            begin
                nxt.out = set_val;
            end
            else if (!we)
            begin
                nxt.out = rd_old;
            end
            else
            begin
                unique case (mode)
                    DPBR_WRITE_FIRST: nxt.out = wr_trim;
                    DPBR_READ_FIRST:  nxt.out = rd_old;
                    DPBR_NO_CHANGE:   nxt.out = cur.out;
                endcase
            end
        end
        return nxt;
    endfunction : port_step

    // Masked merge of a port's write into a stored word
    function automatic logic [WORD_BITS-1:0] merge(
        input logic [WORD_BITS-1:0] base,
        input logic [WORD_BITS-1:0] mask,
        input logic [WORD_BITS-1:0] wword
    );
        return (base & ~mask) | (wword & mask);
    endfunction : merge

    // ====================================================================
    // Per-port lane alignment
    // ====================================================================
    dpbr_lane #(
        .WIDTH (A_WIDTH)
    ) u_lane_a (
        .addr_i  (a_addr_i),
        .wdata_i (a_write_data_in_i),
        .wpar_i  (a_write_par_i),
        .rword_i (a_old),
        .word_o  (a_word),
        .mask_o  (a_mask),
        .wword_o (a_wword),
        .rtrim_o (a_rtrim),
        .wtrim_o (a_wtrim)
    );

    dpbr_lane #(
        .WIDTH (B_WIDTH)
    ) u_lane_b (
        .addr_i  (b_addr_i),
        .wdata_i (b_write_data_in_i),
        .wpar_i  (b_write_par_i),
        .rword_i (b_old),
        .word_o  (b_word),
        .mask_o  (b_mask),
        .wword_o (b_wword),
        .rtrim_o (b_rtrim),
        .wtrim_o (b_wtrim)
    );

    // ====================================================================
    // Next state
    // ====================================================================
    // Port clocks arrive as synchronous levels; an edge is seen one
    // system cycle after the level changes, so the port clock must stay
    // well below half the system rate
    always_comb
    begin
        a_clk_eff = a_clk_i ^ A_CLK_INV;
        b_clk_eff = b_clk_i ^ B_CLK_INV;
        a_fire    = a_clk_eff && !st_ff.a.clk_prev &&
                    (a_en_i ^ A_EN_INV);
        b_fire    = b_clk_eff && !st_ff.b.clk_prev &&
                    (b_en_i ^ B_EN_INV);
        a_wr      = a_fire && (a_we_i ^ A_WE_INV);
        b_wr      = b_fire && (b_we_i ^ B_WE_INV);
        a_old     = mem[a_word];
        b_old     = mem[b_word];
        b_new     = merge(b_old, b_mask, b_wword);
        // Same word written by both: A merges over B, A wins on overlap
        a_new     = merge((b_wr && (a_word == b_word)) ? b_new : a_old,
                          a_mask, a_wword);
        nxt_st    = st_ff;
        if (!rst_n_i)
        begin
            nxt_st.a.clk_prev = RST_CLK_PREV;
            nxt_st.a.out      = A_INIT_VAL;
            nxt_st.b.clk_prev = RST_CLK_PREV;
            nxt_st.b.out      = B_INIT_VAL;
        end
        else
        begin
            // Same function for both ports keeps them identical
            nxt_st.a = port_step(st_ff.a, a_clk_eff, a_fire,
                                 a_we_i ^ A_WE_INV,
                                 a_sync_output_set_i ^ A_SET_INV,
                                 A_SET_VAL, A_MODE,
                                 a_rtrim, a_wtrim);
            nxt_st.b = port_step(st_ff.b, b_clk_eff, b_fire,
                                 b_we_i ^ B_WE_INV,
                                 b_sync_output_set_i ^ B_SET_INV,
                                 B_SET_VAL, B_MODE,
                                 b_rtrim, b_wtrim);
        end
    end

    // ====================================================================
    // Registers
    // ====================================================================
    always_ff @(posedge sys_clk_i)
    begin
        st_ff <= nxt_st;
    end

    // Storage keeps its content through reset
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_n_i && b_wr)
        begin
            mem[b_word] <= b_new;
        end
        if (rst_n_i && a_wr)
        begin
            mem[a_word] <= a_new;
        end
    end

    // ====================================================================
    // Outputs
    // ====================================================================
    assign a_read_data_o = st_ff.a.out[DATA_BITS-1:0];
    assign a_read_par_o  = st_ff.a.out[WORD_BITS-1:DATA_BITS];
    assign b_read_data_o = st_ff.b.out[DATA_BITS-1:0];
    assign b_read_par_o  = st_ff.b.out[WORD_BITS-1:DATA_BITS];

endmodule : dpbr_ram

//--- testbench/dpbr_ram_monitor.sv
// Concurrent checks on the ports of the dual-port block memory
`timescale 1ns/1ps
module dpbr_ram_monitor
    import dpbr_pkg::*;
#(
    parameter int                   A_WIDTH   = DEF_WIDTH,
    parameter dpbr_wmode_t          A_MODE    = DPBR_WRITE_FIRST,
    parameter logic                 A_CLK_INV = DEF_INV,
    parameter logic                 A_EN_INV  = DEF_INV,
    parameter logic                 A_WE_INV  = DEF_INV,
    parameter logic                 A_SET_INV = DEF_INV,
    parameter logic [WORD_BITS-1:0] A_SET_VAL = DEF_SET_VAL,
    parameter dpbr_wmode_t          B_MODE    = DPBR_WRITE_FIRST,
    parameter logic                 B_CLK_INV = DEF_INV,
    parameter logic                 B_EN_INV  = DEF_INV,
    parameter logic                 B_WE_INV  = DEF_INV,
    parameter logic                 B_SET_INV = DEF_INV,
    parameter logic [WORD_BITS-1:0] B_SET_VAL = DEF_SET_VAL
)(
    input  wire logic                 sys_clk_i,           // Clock
    input  wire logic                 rst_n_i,             // Reset
    input  wire logic                 a_clk_i,             // A clock
    input  wire logic                 a_en_i,              // A enable
    input  wire logic                 a_we_i,              // A write
    input  wire logic                 a_sync_output_set_i, // A set
    input  wire logic [ADDR_BITS-1:0] a_addr_i,            // A address
    input  wire logic [DATA_BITS-1:0] a_write_data_in_i,   // A data
    input  wire logic [PAR_BITS-1:0]  a_write_par_i,       // A parity
    input  wire logic [DATA_BITS-1:0] a_read_data_o,       // A read data
    input  wire logic [PAR_BITS-1:0]  a_read_par_o,        // A read parity
    input  wire logic                 b_clk_i,             // B clock
    input  wire logic                 b_en_i,              // B enable
    input  wire logic                 b_we_i,              // B write
    input  wire logic                 b_sync_output_set_i, // B set
    input  wire logic [ADDR_BITS-1:0] b_addr_i,            // B address
    input  wire logic [DATA_BITS-1:0] b_write_data_in_i,   // B data
    input  wire logic [PAR_BITS-1:0]  b_write_par_i,       // B parity
    input  wire logic [DATA_BITS-1:0] b_read_data_o,       // B read data
    input  wire logic [PAR_BITS-1:0]  b_read_par_o         // B read parity
);
    // ====================================================================
    // Edge tracking, mirrors the reset-high previous level
    // ====================================================================
    logic                 a_prev_ff, b_prev_ff, a_ce, b_ce, a_en, b_en;
    logic                 a_fire, b_fire, a_we, b_we, a_set, b_set;
    logic [WORD_BITS-1:0] a_q, b_q;
    assign a_ce   = a_clk_i ^ A_CLK_INV;
    assign b_ce   = b_clk_i ^ B_CLK_INV;
    assign a_en   = a_en_i ^ A_EN_INV;
    assign b_en   = b_en_i ^ B_EN_INV;
    assign a_we   = a_we_i ^ A_WE_INV;
    assign b_we   = b_we_i ^ B_WE_INV;
    assign a_set  = a_sync_output_set_i ^ A_SET_INV;
    assign b_set  = b_sync_output_set_i ^ B_SET_INV;
    assign a_fire = a_ce & ~a_prev_ff & a_en;
    assign b_fire = b_ce & ~b_prev_ff & b_en;
    assign a_q    = {a_read_par_o, a_read_data_o};
    assign b_q    = {b_read_par_o, b_read_data_o};
    always_ff @(posedge sys_clk_i)
    begin
        a_prev_ff <= rst_n_i ? a_ce : 1'b1;
        b_prev_ff <= rst_n_i ? b_ce : 1'b1;
    end
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence a_edge_s; a_ce && !a_prev_ff; endsequence
    sequence b_edge_s; b_ce && !b_prev_ff; endsequence
    // ====================================================================
    // Properties
    // ====================================================================
    a_out_hold: assert property (!a_fire |=> $stable(a_q))
        else $error("port A output moved without an active edge");
    a_hold_port_b: assert property (!b_fire |=> $stable(b_q))
        else $error("port B output moved without an active edge");
    a_set_value: assert property
        (a_fire && a_set |=> a_q == A_SET_VAL)
        else $error("port A set value not loaded");
    a_set_port_b: assert property
        (b_fire && b_set |=> b_q == B_SET_VAL)
        else $error("port B set value not loaded");
    a_write_thru: assert property
        (a_fire && !a_set && a_we
        && A_MODE == DPBR_WRITE_FIRST && A_WIDTH == 36
        |=> a_q == $past({a_write_par_i, a_write_data_in_i}))
        else $error("port A output is not the written word");
    a_keep_port_b: assert property
        (b_fire && !b_set && b_we && B_MODE == DPBR_NO_CHANGE
        |=> $stable(b_q))
        else $error("port B output changed on a write");
    a_gated_edge: assert property
        (a_edge_s ##0 !a_en |=> $stable(a_q) [*2])
        else $error("port A acted while disabled");
    a_gate_port_b: assert property
        (b_edge_s ##0 !b_en |=> $stable(b_q) [*2])
        else $error("port B acted while disabled");
endmodule : dpbr_ram_monitor

bind dpbr_ram dpbr_ram_monitor #(
    .A_WIDTH(A_WIDTH), .A_MODE(A_MODE), .A_CLK_INV(A_CLK_INV),
    .A_EN_INV(A_EN_INV), .A_WE_INV(A_WE_INV), .A_SET_INV(A_SET_INV),
    .A_SET_VAL(A_SET_VAL), .B_MODE(B_MODE), .B_CLK_INV(B_CLK_INV),
    .B_EN_INV(B_EN_INV), .B_WE_INV(B_WE_INV), .B_SET_INV(B_SET_INV),
    .B_SET_VAL(B_SET_VAL)
) u_mon (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .a_clk_i(a_clk_i),
    .a_en_i(a_en_i), .a_we_i(a_we_i), .a_addr_i(a_addr_i),
    .a_sync_output_set_i(a_sync_output_set_i),
    .a_write_data_in_i(a_write_data_in_i), .a_write_par_i(a_write_par_i),
    .a_read_data_o(a_read_data_o), .a_read_par_o(a_read_par_o),
    .b_clk_i(b_clk_i), .b_en_i(b_en_i), .b_we_i(b_we_i),
    .b_sync_output_set_i(b_sync_output_set_i), .b_addr_i(b_addr_i),
    .b_write_data_in_i(b_write_data_in_i), .b_write_par_i(b_write_par_i),
    .b_read_data_o(b_read_data_o), .b_read_par_o(b_read_par_o)
);

//--- testbench/dpbr_user.sv
// Fabric-side user logic model driving one memory port
`timescale 1ns/1ps
module dpbr_user
    import dpbr_pkg::*;
#(
    parameter int   WIDTH   = DEF_WIDTH,
    parameter logic CLK_INV = DEF_INV,
    parameter logic EN_INV  = DEF_INV,
    parameter logic WE_INV  = DEF_INV,
    parameter logic SET_INV = DEF_INV
)(
    input  wire logic                 sys_clk_i, // System clock
    output logic                      pclk_o,    // Port clock
    output logic                      en_o,      // Enable
    output logic                      we_o,      // Write strobe
    output logic                      set_o,     // Output set
    output logic      [ADDR_BITS-1:0] addr_o,    // Address
    output logic      [DATA_BITS-1:0] data_o,    // Write data
    output logic      [PAR_BITS-1:0]  par_o      // Write parity
);
    localparam int PW = WIDTH >= 36 ? 4 : WIDTH >= 18 ? 2 : WIDTH >= 9 ? 1 : 0;
    initial
    begin
        {pclk_o, en_o, we_o, set_o} = {CLK_INV, EN_INV, WE_INV, SET_INV};
        {addr_o, data_o, par_o} = '0;
    end
    // Clock idles at its inactive level CLK_INV between operations, controls released to idle
    task automatic op(input logic en, input logic we, input logic set,
                      input logic [ADDR_BITS-1:0] addr,
                      input logic [DATA_BITS-1:0] data, input int slow);
        @(posedge sys_clk_i);
        #1;
        {en_o, we_o, set_o} = {en ^ EN_INV, we ^ WE_INV, set ^ SET_INV};
        addr_o = addr;
        data_o = data;
        for (int k = 0; k < PAR_BITS; k++)
            par_o[k] = (k < PW) ? ^data[8*k +: 8] : 1'b0;
        repeat (slow) @(posedge sys_clk_i);
        @(posedge sys_clk_i);
        #1 pclk_o = ~CLK_INV;
        @(posedge sys_clk_i);
        #1;
        {pclk_o, en_o, we_o, set_o} = {CLK_INV, EN_INV, WE_INV, SET_INV};
        {addr_o, data_o, par_o} = ~{addr_o, data_o, par_o};
    endtask : op
endmodule : dpbr_user

//--- testbench/tb.sv
// Self-checking bench for the dual-port block memory
`timescale 1ns/1ps
module tb;
    import dpbr_pkg::*;
    localparam logic [WORD_BITS-1:0] A_SV = 36'h9_1234_abcd;
    localparam logic [WORD_BITS-1:0] B_SV = 36'h1_0000_005a;
    localparam logic [WORD_BITS-1:0] A_IV = 36'h6_0000_0077;
    localparam int                   B_W  = 9;
    localparam int                   N_W  = 4;
    localparam logic                 B_IV = 1'b1;
    logic                 sys_clk_i, rst_n_i, ac, ae, aw, as, bc, be, bw, bs;
    logic [ADDR_BITS-1:0] aa, ba;
    logic [DATA_BITS-1:0] ad, bd, ard, brd, frd, nbd;
    logic [PAR_BITS-1:0]  ap, bp, arp, brp, frp, nbp;
    logic [WORD_BITS-1:0] w, old;
    int                   n_mismatch, comparisons;
    dpbr_user usr_a (.sys_clk_i(sys_clk_i), .pclk_o(ac), .en_o(ae), .we_o(aw),
        .set_o(as), .addr_o(aa), .data_o(ad), .par_o(ap));
    dpbr_user #(.WIDTH(B_W), .CLK_INV(B_IV), .EN_INV(B_IV), .SET_INV(B_IV))
    usr_b (.sys_clk_i(sys_clk_i), .pclk_o(bc), .en_o(be), .we_o(bw),
        .set_o(bs), .addr_o(ba), .data_o(bd), .par_o(bp));
    dpbr_ram #(.A_SET_VAL(A_SV), .A_INIT_VAL(A_IV), .B_WIDTH(B_W),
        .B_MODE(DPBR_NO_CHANGE), .B_CLK_INV(B_IV), .B_EN_INV(B_IV),
        .B_SET_INV(B_IV), .B_SET_VAL(B_SV)) dut (
        .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .a_clk_i(ac), .a_en_i(ae),
        .a_we_i(aw), .a_sync_output_set_i(as), .a_addr_i(aa),
        .a_write_data_in_i(ad), .a_write_par_i(ap), .a_read_data_o(ard),
        .a_read_par_o(arp), .b_clk_i(bc), .b_en_i(be), .b_we_i(bw),
        .b_sync_output_set_i(bs), .b_addr_i(ba), .b_write_data_in_i(bd),
        .b_write_par_i(bp), .b_read_data_o(brd), .b_read_par_o(brp));
    // Same stimulus, port A read-before-write, port B narrow with no parity
    dpbr_ram #(.A_MODE(DPBR_READ_FIRST), .B_WIDTH(N_W),
        .B_MODE(DPBR_NO_CHANGE), .B_CLK_INV(B_IV), .B_EN_INV(B_IV),
        .B_SET_INV(B_IV)) dut_rf (
        .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .a_clk_i(ac), .a_en_i(ae),
        .a_we_i(aw), .a_sync_output_set_i(as), .a_addr_i(aa),
        .a_write_data_in_i(ad), .a_write_par_i(ap), .a_read_data_o(frd),
        .a_read_par_o(frp), .b_clk_i(bc), .b_en_i(be), .b_we_i(bw),
        .b_sync_output_set_i(bs), .b_addr_i(ba), .b_write_data_in_i(bd),
        .b_write_par_i(bp), .b_read_data_o(nbd), .b_read_par_o(nbp));
    function automatic logic [WORD_BITS-1:0] wd(input logic [31:0] d);
        return {^d[31:24], ^d[23:16], ^d[15:8], ^d[7:0], d};
    endfunction : wd
    task automatic chk(input string name, input logic [WORD_BITS-1:0] exp,
                       input logic [WORD_BITS-1:0] got);
        comparisons++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : complete_run
    initial
    begin
        sys_clk_i = 1'b0;
        forever #2 sys_clk_i = ~sys_clk_i;
    end
    initial
    begin
        #8000;
        n_mismatch++;
        complete_run();
    end
    initial
    begin
        rst_n_i = 1'b0;
        repeat (3) @(posedge sys_clk_i);
        #1 rst_n_i = 1'b1;
        chk("a after reset", A_IV, {arp, ard});
        usr_a.op(1, 1, 0, 14'h5, 32'h1234_5678, 0);
        chk("a write first", wd(32'h1234_5678), {arp, ard});
        w = wd(32'hdead_beef);
        usr_a.op(1, 1, 0, 14'h5, 32'hdead_beef, 2);
        chk("a write first", w, {arp, ard});
        chk("a read first", wd(32'h1234_5678), {frp, frd});
        usr_a.op(1, 0, 0, 14'h5, 32'h0, 0);
        chk("a read", w, {arp, ard});
        for (int k = 0; k < 4; k++)
        begin
            usr_b.op(1, 0, 0, {3'b0, 9'h005, 2'(k)}, 32'h0, 0);
            old = {3'b0, w[32+k], 24'h0, w[8*k +: 8]};
            chk("b lane", old, {brp, brd});
        end
        usr_b.op(1, 1, 0, {3'b0, 9'h005, 2'd1}, 32'h3d, 0);
        chk("b write hold", old, {brp, brd});
        usr_b.op(1, 0, 0, {3'b0, 9'h005, 2'd1}, 32'h0, 1);
        chk("b readback", 36'h1_0000_003d, {brp, brd});
        chk("b narrow", 36'h0_0000_000d, {nbp, nbd});
        w[15:8] = 8'h3d;
        w[33] = 1'b1;
        usr_a.op(1, 0, 0, 14'h5, 32'h0, 0);
        chk("a shared", w, {arp, ard});
        usr_a.op(0, 1, 1, 14'h5, 32'h0, 0);
        chk("a disabled", w, {arp, ard});
        usr_a.op(1, 0, 0, 14'h5, 32'h0, 0);
        chk("a no write", w, {arp, ard});
        usr_a.op(1, 0, 1, 14'h5, 32'h0, 0);
        chk("a set", A_SV, {arp, ard});
        usr_b.op(1, 0, 1, 14'h0, 32'h0, 0);
        chk("b set", B_SV, {brp, brd});
        complete_run();
    end
endmodule : tb
